// ### dyn_map.vh
`ifndef DYN_MAP_VH
`define DYN_MAP_VH

// ==========================================================
// Register indexes (byte address is four times the index)
// ==========================================================
`define IDX_ADJ_EN    8'h0B
`define IDX_PERIOD    8'h0C
`define IDX_TGT1      8'h5A
`define IDX_TGT2      8'h5B
`define IDX_HYST      8'h64
`define IDX_THR1      8'h70
`define IDX_THR2      8'h71
`define IDX_ALERT     8'h72

// ==========================================================
// Reset values
// ==========================================================
`define RST_ADJ_EN    8'h00
`define RST_PERIOD    8'h00
`define RST_TGT       8'hA4
`define RST_HYST      8'h40

// ==========================================================
// Field positions
// ==========================================================
`define EN_LSB        0
`define TRIP_LSB      2
`define TRIP_W        4
`define PER_LSB       0
`define PER_W         3
`define HYST_LSB      4
`define HYST_W        4

// ==========================================================
// Loop arithmetic
// ==========================================================
`define SHORT_BASE    11'h008
`define THR_FLOOR     10'h000
`define ONE_DEG       10'h001
`define RISE_MIN      11'h001

`endif

// ### dynamic_fan_threshold_adjust.v
// Operation
// - Two 8-bit zone target registers, one per remote channel, 1 degree steps.
// - Both zone targets reset to 0xA4, meaning 100 degrees.
// - Hysteresis field bits 7:4 sets decrease start below target; default 4.
// - Each enabled channel runs decrease loop every n, increase loop every 2n.
// - Period code is 3 bits: channel 1 bits 2:0, channel 2 bits 5:3.
// - Code 000 gives 8 ticks, doubling per code; increase period is twice.
// - Above target minus hysteresis, decrease lowers threshold by twice the rise.
// - Rise of 0.25 degree or less per decrease period changes nothing.
// - Between target minus hysteresis and target, increase loop does not lower the threshold.
// - Above target, each increase period lowers threshold one degree more.
// - Below target minus hysteresis the threshold holds unless raise conditions are met.
// - Raise only if below low limit, above threshold, under high and target.
// - Threshold never rises above the channel high limit.
// - Threshold never goes below minus 64 degrees.
// - Temperature below threshold suspends all adjustment for that channel.
// - Control bit 0 enables channel 1, bit 1 enables channel 2.
// - Disabled channel keeps its programmed threshold fixed.
// - Flag temperature below low limit and above high limit.
// - Control bits 3:2 let a trip copy the temperature into the target.
`timescale 1ns/1ps
`default_nettype none
`include "dyn_map.vh"

module dynamic_fan_threshold_adjust #(
  parameter NCH = 2
) (
  input  wire              sys_clk_i,
  input  wire              reset_n_i,
  // APB slave
  input  wire              psel_i,
  input  wire              penable_i,
  input  wire              pwrite_i,
  input  wire [9:0]        paddr_i,
  input  wire [31:0]       pwdata_i,
  output reg  [31:0]       prdata_o,
  output reg               pready_o,
  output reg               pslverr_o,
  // Monitoring side, same clock
  input  wire              mon_tick_i,
  input  wire [NCH*10-1:0] zone_temp_i,
  input  wire [NCH*8-1:0]  low_limit_i,
  input  wire [NCH*8-1:0]  high_limit_i,
  input  wire [NCH*8-1:0]  thr_prog_i,
  input  wire              thermal_trip_input_n_i,
  // Results
  output reg  [NCH*8-1:0]  fan_on_threshold_o,
  output reg  [NCH-1:0]    low_alert_o,
  output reg  [NCH-1:0]    high_alert_o
);

  // ==========================================================
  // APB decode
  // ==========================================================
  wire [7:0] idx   = paddr_i[9:2];
  wire       first = psel_i & penable_i & ~pready_o;
  wire       acc   = psel_i & penable_i & pready_o;
  wire       wr    = acc & pwrite_i;
  wire       align = (paddr_i[1:0] == 2'b00);

  reg  [7:0] adj_en_q;
  reg  [7:0] period_q;
  reg  [7:0] hyst_q;
  wire [NCH*8-1:0] tgt_all;

  wire wr_en  = wr & align & (idx == `IDX_ADJ_EN);
  wire wr_per = wr & align & (idx == `IDX_PERIOD);
  wire wr_hys = wr & align & (idx == `IDX_HYST);

  wire [3:0] hyst = hyst_q[`HYST_LSB +: `HYST_W];

  // ==========================================================
  // Control registers
  // ==========================================================
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      adj_en_q <= `RST_ADJ_EN;
      period_q <= `RST_PERIOD;
      hyst_q   <= `RST_HYST;
    end else begin
      if (wr_en) begin
        adj_en_q <= pwdata_i[7:0];
      end
      if (wr_per) begin
        period_q <= pwdata_i[7:0];
      end
      if (wr_hys) begin
        hyst_q <= pwdata_i[7:0];
      end
    end
  end

  // ==========================================================
  // Read mux and bus answer
  // ==========================================================
  reg [7:0] rd_byte;
  reg       rd_hit;

  always @* begin
    rd_byte = 8'h00;
    rd_hit  = align;
    case (idx)
      `IDX_ADJ_EN: rd_byte = adj_en_q;
      `IDX_PERIOD: rd_byte = period_q;
      `IDX_TGT1:   rd_byte = tgt_all[7:0];
      `IDX_TGT2:   rd_byte = tgt_all[15:8];
      `IDX_HYST:   rd_byte = hyst_q;
      `IDX_THR1:   rd_byte = fan_on_threshold_o[7:0];
      `IDX_THR2:   rd_byte = fan_on_threshold_o[15:8];
      `IDX_ALERT:  rd_byte = {4'h0, high_alert_o, low_alert_o};
      default:     rd_hit  = 1'b0;
    endcase
    if (!align) begin
      rd_byte = 8'h00;
    end
  end

  // One wait state: data and error are registered in the first access
  // cycle so that every bus output comes straight from a flip-flop.
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= first;
      if (first) begin
        prdata_o  <= pwrite_i ? 32'h0000_0000 : {24'h000000, rd_byte};
        pslverr_o <= ~rd_hit;
      end else begin
        pslverr_o <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Trip input synchroniser
  // ==========================================================
  reg trip_s1_q;
  reg trip_s2_q;
  reg trip_s3_q;

  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      trip_s1_q <= 1'b1;
      trip_s2_q <= 1'b1;
      trip_s3_q <= 1'b1;
    end else begin
      trip_s1_q <= thermal_trip_input_n_i;
      trip_s2_q <= trip_s1_q;
      trip_s3_q <= trip_s2_q;
    end
  end

  // The trip is active low; only its assertion edge copies.
  wire trip_fall = trip_s3_q & ~trip_s2_q;

  // ==========================================================
  // Per-channel adjustment
  // ==========================================================
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch = ch + 1) begin : g_ch
      wire [9:0] t    = zone_temp_i[ch*10 +: 10];
      wire [7:0] ti   = t[9:2];
      wire [7:0] lo   = low_limit_i[ch*8 +: 8];
      wire [7:0] hi   = high_limit_i[ch*8 +: 8];
      wire [2:0] pc   = period_q[`PER_LSB + ch*`PER_W +: `PER_W];
      wire       en   = adj_en_q[`EN_LSB + ch];
      wire       trip = adj_en_q[`TRIP_LSB + ch];

      reg  [7:0]  tgt_q;
      reg  [7:0]  thr_q;
      reg  [10:0] cnt_q;
      reg  [9:0]  prev_q;
      reg  [9:0]  sref_q;

      wire wr_tgt = wr & align & (idx == (`IDX_TGT1 + ch));

      // Zone target; a trip copy wins over a same-cycle bus write.
      always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          tgt_q <= `RST_TGT;
        end else if (trip_fall && trip) begin
          tgt_q <= ti;
        end else if (wr_tgt) begin
          tgt_q <= pwdata_i[7:0];
        end
      end

      assign tgt_all[ch*8 +: 8] = tgt_q;

      // Short period is 8 << code; long period is twice that.
      wire [10:0] smask = (`SHORT_BASE << pc) - 11'h001;
      wire [10:0] lmax  = {smask[9:0], 1'b1};
      wire short_hit = mon_tick_i & ((cnt_q & smask) == smask);
      wire long_hit  = mon_tick_i & (cnt_q >= lmax);

      always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          cnt_q  <= 11'h000;
          prev_q <= 10'h000;
          sref_q <= 10'h000;
        end else begin
          if (!en) begin
            cnt_q <= 11'h000;
          end else if (mon_tick_i) begin
            cnt_q <= long_hit ? 11'h000 : cnt_q + 11'h001;
          end
          if (mon_tick_i) begin
            prev_q <= t;
          end
          if (short_hit) begin
            sref_q <= t;
          end
        end
      end

      // Rises are in quarter degrees; a signed 11-bit span covers them.
      wire signed [10:0] rise  = $signed({1'b0, t}) - $signed({1'b0, prev_q});
      wire signed [10:0] rperd = $signed({1'b0, t}) - $signed({1'b0, sref_q});
      // Twice the rise in degrees is the rise in quarters halved.
      wire [9:0] dec_short = (rise > 0) ? rise[10:1] : 10'h000;
      wire       rise_ok   = rperd > $signed(`RISE_MIN);

      wire signed [9:0] band = $signed({2'b00, tgt_q}) - $signed({6'h00, hyst});
      wire above_band = $signed({2'b00, ti}) > band;
      wire above_tgt  = ti > tgt_q;
      wire active     = en & (ti >= thr_q);

      wire do_short = short_hit & above_band & rise_ok;
      wire do_long  = long_hit & above_tgt;
      wire do_raise = long_hit & (ti < lo) & (ti > thr_q) &
                      (thr_q < hi) & (thr_q < tgt_q);

      wire [9:0] dec_amt = (do_short ? dec_short : 10'h000) +
                           (do_long ? `ONE_DEG : 10'h000);
      wire [9:0] inc_amt = do_raise ? `ONE_DEG : 10'h000;
      wire [9:0] base    = {2'b00, thr_q} + inc_amt;
      // Underflow shows as the sum falling below the decrement.
      wire       under   = base < dec_amt;
      wire [9:0] diff    = under ? `THR_FLOOR : base - dec_amt;
      wire       over    = (inc_amt != 10'h000) & (diff > {2'b00, hi});
      wire [7:0] thr_new = over ? hi : diff[7:0];

      always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          thr_q <= 8'h00;
        end else if (!en) begin
          thr_q <= thr_prog_i[ch*8 +: 8];
        end else if (active) begin
          thr_q <= thr_new;
        end
      end

      always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          fan_on_threshold_o[ch*8 +: 8] <= 8'h00;
          low_alert_o[ch]               <= 1'b0;
          high_alert_o[ch]              <= 1'b0;
        end else begin
          fan_on_threshold_o[ch*8 +: 8] <= thr_q;
          low_alert_o[ch]               <= ti < lo;
          high_alert_o[ch]              <= ti > hi;
        end
      end
    end
  endgenerate

endmodule // dynamic_fan_threshold_adjust

`default_nettype wire

// ### dynamic_fan_threshold_adjust_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Port checker
// ==========================================================
module dyn_adj_chk #(
  parameter NCH = 2
) (
  input wire logic              sys_clk_i,
  input wire logic              reset_n_i,
  input wire logic              psel_i,
  input wire logic              penable_i,
  input wire logic [9:0]        paddr_i,
  input wire logic [31:0]       prdata_o,
  input wire logic              pready_o,
  input wire logic              pslverr_o,
  input wire logic [NCH*10-1:0] zone_temp_i,
  input wire logic [NCH*8-1:0]  low_limit_i,
  input wire logic [NCH*8-1:0]  high_limit_i,
  input wire logic [NCH-1:0]    low_alert_o,
  input wire logic [NCH-1:0]    high_alert_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  one_wait_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("ready missing after one wait state");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  err_with_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  upper_zero_a: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  misalign_err_a: assert property (psel_i && penable_i && !pready_o && paddr_i[1:0] != 2'b00 |=> pslverr_o)
    else $error("misaligned access not refused");
  low_alert_a: assert property (zone_temp_i[9:2] < low_limit_i[7:0] |=> low_alert_o[0])
    else $error("low alert missing");
  no_low_a: assert property (zone_temp_i[9:2] >= low_limit_i[7:0] |=> !low_alert_o[0])
    else $error("low alert spurious");
  high_alert_a: assert property (zone_temp_i[9:2] > high_limit_i[7:0] |=> high_alert_o[0])
    else $error("high alert missing");

  cover property (pready_o && !pslverr_o);
  cover property (pslverr_o);
  cover property (low_alert_o[1]);
endmodule // dyn_adj_chk

bind dynamic_fan_threshold_adjust dyn_adj_chk #(.NCH(NCH)) dyn_adj_chk_i (
  .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .zone_temp_i(zone_temp_i), .low_limit_i(low_limit_i), .high_limit_i(high_limit_i),
  .low_alert_o(low_alert_o), .high_alert_o(high_alert_o));
`default_nettype wire

// ### dynamic_fan_threshold_adjust_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dyn_map.vh"
// ==========================================================
// Bench
// ==========================================================
module dynamic_fan_threshold_adjust_bench;
  logic        sys_clk_i = 1'b0, reset_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
  logic        pwrite_i = 1'b0, mon_tick_i = 1'b0, thermal_trip_input_n_i = 1'b1;
  logic [9:0]  paddr_i = 10'h000;
  logic [31:0] pwdata_i = 32'h0, rd;
  logic [19:0] zone_temp_i = 20'h0;
  logic [15:0] low_limit_i = 16'h0, high_limit_i = 16'hFFFF, thr_prog_i = 16'h0;
  logic [7:0]  d, ri [5], rv [5];
  wire  [31:0] prdata_o;
  wire         pready_o, pslverr_o;
  wire  [15:0] thr_o;
  wire  [1:0]  low_o, high_o;
  logic        er;
  int          mismatches = 0, samples_checked = 0, p;

  always #10 sys_clk_i = ~sys_clk_i;

  dynamic_fan_threshold_adjust dynamic_fan_threshold_adjust_i (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .mon_tick_i(mon_tick_i), .zone_temp_i(zone_temp_i),
    .low_limit_i(low_limit_i), .high_limit_i(high_limit_i), .thr_prog_i(thr_prog_i),
    .thermal_trip_input_n_i(thermal_trip_input_n_i), .fan_on_threshold_o(thr_o),
    .low_alert_o(low_o), .high_alert_o(high_o));

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // Holds the request until the edge that sees ready; the design always adds one wait state.
  task apb(input logic w, input logic [9:0] a, input logic [7:0] v);
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h0, v};
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do @(posedge sys_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task tick(input int c, input logic [7:0] t);
    @(posedge sys_clk_i);
    mon_tick_i <= 1'b1;
    zone_temp_i[c*10 +: 10] <= {t, 2'b00};
    @(posedge sys_clk_i);
    mon_tick_i <= 1'b0;
  endtask

  // Disabling first clears the loop counter, so every scenario starts at a period boundary.
  task sc(input int c, input logic [7:0] tg, tp, t0, t1, lo, hi, input int n, input logic [7:0] e);
    apb(1'b1, {`IDX_ADJ_EN, 2'b00}, 8'h00);
    thr_prog_i[c*8 +: 8] <= tp;
    low_limit_i[c*8 +: 8] <= lo;
    high_limit_i[c*8 +: 8] <= hi;
    zone_temp_i[c*10 +: 10] <= {t0, 2'b00};
    apb(1'b1, {(c != 0) ? `IDX_TGT2 : `IDX_TGT1, 2'b00}, tg);
    chk("threshold disabled", {24'h0, tp}, {24'h0, thr_o[c*8 +: 8]});
    apb(1'b1, {`IDX_ADJ_EN, 2'b00}, 8'(1 << c));
    for (int i = 0; i < n; i++) tick(c, (i >= 7) ? t1 : t0);
    repeat (2) @(posedge sys_clk_i);
    chk("threshold", {24'h0, e}, {24'h0, thr_o[c*8 +: 8]});
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #1000000;
    mismatches++;
    end_sim;
  end

  initial begin
    ri = '{`IDX_ADJ_EN, `IDX_PERIOD, `IDX_TGT1, `IDX_TGT2, `IDX_HYST};
    rv = '{`RST_ADJ_EN, `RST_PERIOD, `RST_TGT, `RST_TGT, `RST_HYST};
    void'($urandom(95));
    repeat (6) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, {ri[i], 2'b00}, 8'h00);
      chk("reset value", {24'h0, rv[i]}, rd);
    end
    repeat (6) begin
      d = 8'($urandom);
      apb(1'b1, {ri[2 + (d[0] ? 1 : 0)], 2'b00}, d);
      apb(1'b0, {ri[2 + (d[0] ? 1 : 0)], 2'b00}, 8'h00);
      chk("target readback", {24'h0, d}, rd);
    end
    apb(1'b0, 10'h0FC, 8'h00);
    chk("unmapped error", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, 10'h169, 8'h55);
    chk("misaligned error", 32'h1, {31'h0, er});
    zone_temp_i[9:0] <= {8'h77, 2'b00};
    apb(1'b1, {`IDX_ADJ_EN, 2'b00}, 8'h04);
    thermal_trip_input_n_i <= 1'b0;
    repeat (5) @(posedge sys_clk_i);
    thermal_trip_input_n_i <= 1'b1;
    apb(1'b0, {`IDX_TGT1, 2'b00}, 8'h00);
    chk("trip copy", 32'h77, rd);
    sc(0, 8'h80, 8'h70, 8'h7E, 8'h7F, 8'h00, 8'hFF, 16, 8'h6E);
    sc(0, 8'h80, 8'h40, 8'h50, 8'h50, 8'h60, 8'h41, 32, 8'h41);
    sc(0, 8'h10, 8'h01, 8'h20, 8'h60, 8'h00, 8'hFF, 8, 8'h00);
    sc(1, 8'h50, 8'h90, 8'h60, 8'h60, 8'h00, 8'hFF, 16, 8'h90);
    sc(1, 8'h80, 8'h40, 8'h50, 8'h50, 8'h60, 8'h70, 32, 8'h42);
    sc(1, 8'h80, 8'h40, 8'h50, 8'h50, 8'h40, 8'h70, 16, 8'h40);
    for (p = 0; p < 3; p++) begin
      apb(1'b1, {`IDX_PERIOD, 2'b00}, 8'(p << 3));
      apb(1'b0, {`IDX_PERIOD, 2'b00}, 8'h00);
      chk("period code", 32'(p << 3), rd);
      sc(1, 8'h80, 8'h70, 8'h90, 8'h90, 8'h00, 8'hFF, (16 << p) - 1, 8'h70);
      sc(1, 8'h80, 8'h70, 8'h90, 8'h90, 8'h00, 8'hFF, 16 << p, 8'h6F);
    end
    end_sim;
  end
endmodule // dynamic_fan_threshold_adjust_bench
`default_nettype wire
